// ### rtl/mahi_regs.svh
`ifndef MAHI_REGS_SVH
`define MAHI_REGS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define MAHI_ADDR_W          5
`define MAHI_OFF_CTRL        5'h00
`define MAHI_OFF_STATUS      5'h04
`define MAHI_OFF_RESULT      5'h08
`define MAHI_OFF_IRQ_STAT    5'h0C
`define MAHI_OFF_IRQ_MASK    5'h10

// CTRL fields
`define MAHI_CTRL_START      0
`define MAHI_CTRL_TIED       1
`define MAHI_CTRL_FOUR       2
`define MAHI_CTRL_CHAN_LO    4
`define MAHI_CTRL_CHAN_HI    5
`define MAHI_CTRL_RST        32'h0000_0000

// STATUS fields
`define MAHI_STAT_BUSY       0
`define MAHI_STAT_DONE_B     1

// RESULT fields
`define MAHI_RES_CHAN_LO     12

// Interrupt bits
`define MAHI_IRQ_DONE        0
`define MAHI_IRQ_TIMEOUT     1
`define MAHI_IRQ_W           2
`define MAHI_IRQ_RST         2'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MAHI_CLK_MHZ         100
`define MAHI_SAMPLE_NS       150
`define MAHI_MUX_SETUP_NS    75
`define MAHI_ACCESS_NS       50
`define MAHI_TIED_VALID_NS   20
`define MAHI_RECOVER_NS      50
`define MAHI_DONE_LIMIT_NS   1000
// Least times round up to whole cycles
`define MAHI_NS2CYC(ns)      ((((ns) * `MAHI_CLK_MHZ) + 999) / 1000)
`define MAHI_SAMPLE_CYC      `MAHI_NS2CYC(`MAHI_SAMPLE_NS)
`define MAHI_MUX_SETUP_CYC   `MAHI_NS2CYC(`MAHI_MUX_SETUP_NS)
`define MAHI_ACCESS_CYC      `MAHI_NS2CYC(`MAHI_ACCESS_NS)
`define MAHI_TIED_VALID_CYC  `MAHI_NS2CYC(`MAHI_TIED_VALID_NS)
`define MAHI_RECOVER_CYC     `MAHI_NS2CYC(`MAHI_RECOVER_NS)
`define MAHI_DONE_LIMIT_CYC  `MAHI_NS2CYC(`MAHI_DONE_LIMIT_NS)

`endif

// ### rtl/mahi_pkg.sv
package mahi_pkg;

	typedef enum logic [5:0] {
		MAHI_IDLE    = 6'h01,
		MAHI_SETUP   = 6'h02,
		MAHI_SAMPLE  = 6'h04,
		MAHI_CONV    = 6'h08,
		MAHI_READ    = 6'h10,
		MAHI_RECOVER = 6'h20
	} mahi_state_type;

	typedef struct packed {
		logic cs_b;
		logic sample_b;
		logic read_b;
		logic channel_pick_hi;
		logic channel_pick_lo;
	} mahi_pins_type;

	typedef struct packed {
		logic [5:0] coarse;
		logic [3:0] fine;
	} mahi_result_type;

endpackage

// ### rtl/mahi_timer.sv
`timescale 1ns/1ns
`default_nettype none

module mahi_timer #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              expired
);

	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	always_comb begin
		if (load) begin
			nxt_cnt = load_val;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - 1'b1;
		end else begin
			nxt_cnt = cnt_ff;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Reload lands on the state change edge, so expiry needs no load term
	assign expired = (cnt_ff == '0);

endmodule

`default_nettype wire

// ### rtl/mahi_ctrl.sv
// Operation
// - Split-strobe and tied-strobe modes both supported
// - Channel picks valid at sample strobe fall
// - Split mode: sample strobe low 150 ns; the sequencer holds it low 160 ns (16 cycles)
// - Chip select low for every strobe
// - Tied mode: both strobes fall together
`timescale 1ns/1ns
`default_nettype none
`include "mahi_regs.svh"

module mahi_ctrl
	import mahi_pkg::*;
#(
	parameter int TW = 8
) (
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic [`MAHI_ADDR_W-1:0] addr,
	input  wire logic [31:0]            wdata,
	input  wire logic                   wr,
	input  wire logic                   rd,
	output logic      [31:0]            rdata,
	output logic                        irq,
	output logic                        cs_b,
	output logic                        sample_b,
	output logic                        read_b,
	output logic                        channel_pick_hi,
	output logic                        channel_pick_lo,
	input  wire logic                   done_b,
	input  wire logic [9:0]             conv_data
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [1:0] pick_map(input logic four, input logic [1:0] chan);
		// Two-input parts ignore the high line, so keep it parked low
		pick_map = four ? chan : {1'b0, chan[0]};
	endfunction

	function automatic logic [TW-1:0] state_wait(input mahi_state_type s, input logic tied);
		case (s)
			MAHI_SETUP:   state_wait = TW'(`MAHI_MUX_SETUP_CYC);
			MAHI_SAMPLE:  state_wait = TW'(`MAHI_SAMPLE_CYC);
			MAHI_CONV:    state_wait = TW'(`MAHI_DONE_LIMIT_CYC);
			MAHI_READ:    state_wait = tied ? TW'(`MAHI_TIED_VALID_CYC) : TW'(`MAHI_ACCESS_CYC);
			MAHI_RECOVER: state_wait = TW'(`MAHI_RECOVER_CYC);
			default:      state_wait = '0;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------------
	logic            tied_ff, nxt_tied;
	logic            four_ff, nxt_four;
	logic [1:0]      chan_ff, nxt_chan;
	logic [1:0]      irq_stat_ff, nxt_irq_stat;
	logic [1:0]      irq_mask_ff, nxt_irq_mask;
	logic [31:0]     rdata_ff, nxt_rdata;
	mahi_result_type result_ff, nxt_result;
	logic [1:0]      res_chan_ff, nxt_res_chan;
	logic            start_req;
	logic [1:0]      irq_set;
	mahi_state_type  state_ff, nxt_state;

	assign start_req = wr && (addr == `MAHI_OFF_CTRL) && wdata[`MAHI_CTRL_START];

	always_comb begin
		nxt_tied     = tied_ff;
		nxt_four     = four_ff;
		nxt_chan     = chan_ff;
		nxt_irq_mask = irq_mask_ff;
		nxt_rdata    = 32'h0000_0000;
		nxt_irq_stat = irq_stat_ff;
		if (wr && addr == `MAHI_OFF_CTRL && state_ff == MAHI_IDLE) begin
			// Mode and channel are frozen while a conversion runs
			nxt_tied = wdata[`MAHI_CTRL_TIED];
			nxt_four = wdata[`MAHI_CTRL_FOUR];
			nxt_chan = wdata[`MAHI_CTRL_CHAN_HI:`MAHI_CTRL_CHAN_LO];
		end
		if (wr && addr == `MAHI_OFF_IRQ_MASK) begin
			nxt_irq_mask = wdata[`MAHI_IRQ_W-1:0];
		end
		if (wr && addr == `MAHI_OFF_IRQ_STAT) begin
			nxt_irq_stat = irq_stat_ff & ~wdata[`MAHI_IRQ_W-1:0];
		end
		// Set wins over a clear in the same cycle
		nxt_irq_stat = nxt_irq_stat | irq_set;
		if (rd) begin
			case (addr)
				`MAHI_OFF_CTRL: begin
					nxt_rdata[`MAHI_CTRL_TIED] = tied_ff;
					nxt_rdata[`MAHI_CTRL_FOUR] = four_ff;
					nxt_rdata[`MAHI_CTRL_CHAN_HI:`MAHI_CTRL_CHAN_LO] = chan_ff;
				end
				`MAHI_OFF_STATUS: begin
					nxt_rdata[`MAHI_STAT_BUSY]   = (state_ff != MAHI_IDLE);
					nxt_rdata[`MAHI_STAT_DONE_B] = done_b;
				end
				`MAHI_OFF_RESULT: begin
					nxt_rdata[9:0] = result_ff;
					nxt_rdata[`MAHI_RES_CHAN_LO+1:`MAHI_RES_CHAN_LO] = res_chan_ff;
				end
				`MAHI_OFF_IRQ_STAT: nxt_rdata[`MAHI_IRQ_W-1:0] = irq_stat_ff;
				`MAHI_OFF_IRQ_MASK: nxt_rdata[`MAHI_IRQ_W-1:0] = irq_mask_ff;
				default:            nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tied_ff     <= 1'(`MAHI_CTRL_RST >> `MAHI_CTRL_TIED);
			four_ff     <= 1'b0;
			chan_ff     <= 2'h0;
			irq_stat_ff <= `MAHI_IRQ_RST;
			irq_mask_ff <= `MAHI_IRQ_RST;
			rdata_ff    <= 32'h0000_0000;
		end else begin
			tied_ff     <= nxt_tied;
			four_ff     <= nxt_four;
			chan_ff     <= nxt_chan;
			irq_stat_ff <= nxt_irq_stat;
			irq_mask_ff <= nxt_irq_mask;
			rdata_ff    <= nxt_rdata;
		end
	end

	assign rdata = rdata_ff;
	assign irq   = |(irq_stat_ff & irq_mask_ff);

	// ------------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------------
	logic          tmr_load;
	logic          tmr_done;
	logic [1:0]    pick;
	mahi_pins_type pins_ff, nxt_pins;

	mahi_timer #(.W(TW)) u_timer (
		.clk      (clk),
		.rst_b    (rst_b),
		.load     (tmr_load),
		.load_val (state_wait(nxt_state, tied_ff)),
		.expired  (tmr_done)
	);

	assign tmr_load = (nxt_state != state_ff);
	// Picks follow the accepted write so they are right when chip select falls
	assign pick     = pick_map(nxt_four, nxt_chan);

	always_comb begin
		nxt_state  = state_ff;
		nxt_result = result_ff;
		nxt_res_chan = res_chan_ff;
		irq_set    = 2'h0;
		case (state_ff)
			MAHI_IDLE: begin
				// A start while busy is simply dropped
				if (start_req) begin
					nxt_state = MAHI_SETUP;
				end
			end
			MAHI_SETUP: begin
				if (tmr_done) begin
					// Tied mode has no host-timed sample phase
					nxt_state = tied_ff ? MAHI_CONV : MAHI_SAMPLE;
				end
			end
			MAHI_SAMPLE: begin
				if (tmr_done) begin
					nxt_state = MAHI_CONV;
				end
			end
			MAHI_CONV: begin
				// Bus data during a tied conversion is still the old word
				if (!done_b) begin
					nxt_state = MAHI_READ;
				end else if (tmr_done) begin
					irq_set[`MAHI_IRQ_TIMEOUT] = 1'b1;
					nxt_state = MAHI_RECOVER;
				end
			end
			MAHI_READ: begin
				if (tmr_done) begin
					nxt_result   = conv_data;
					nxt_res_chan = chan_ff;
					irq_set[`MAHI_IRQ_DONE] = 1'b1;
					nxt_state = MAHI_RECOVER;
				end
			end
			MAHI_RECOVER: begin
				// Covers done_b rising after read and the gap to the next start
				if (tmr_done) begin
					nxt_state = MAHI_IDLE;
				end
			end
			default: nxt_state = MAHI_IDLE;
		endcase
	end

	always_comb begin
		nxt_pins.cs_b            = 1'b1;
		nxt_pins.sample_b        = 1'b1;
		nxt_pins.read_b          = 1'b1;
		nxt_pins.channel_pick_hi = pick[1];
		nxt_pins.channel_pick_lo = pick[0];
		case (nxt_state)
			MAHI_SETUP: nxt_pins.cs_b = 1'b0;
			MAHI_SAMPLE: begin
				nxt_pins.cs_b     = 1'b0;
				nxt_pins.sample_b = 1'b0;
			end
			MAHI_CONV, MAHI_READ: begin
				nxt_pins.cs_b     = 1'b0;
				nxt_pins.sample_b = !tied_ff;
				nxt_pins.read_b   = !tied_ff && (nxt_state != MAHI_READ);
			end
			default: nxt_pins.cs_b = 1'b1;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff    <= MAHI_IDLE;
			result_ff   <= '0;
			res_chan_ff <= 2'h0;
			pins_ff     <= '{cs_b: 1'b1, sample_b: 1'b1, read_b: 1'b1,
			                 channel_pick_hi: 1'b0, channel_pick_lo: 1'b0};
		end else begin
			state_ff    <= nxt_state;
			result_ff   <= nxt_result;
			res_chan_ff <= nxt_res_chan;
			pins_ff     <= nxt_pins;
		end
	end

	assign cs_b            = pins_ff.cs_b;
	assign sample_b        = pins_ff.sample_b;
	assign read_b          = pins_ff.read_b;
	assign channel_pick_hi = pins_ff.channel_pick_hi;
	assign channel_pick_lo = pins_ff.channel_pick_lo;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic [7:0] low_cnt_ff;
	logic [7:0] nxt_low_cnt;

	always_comb begin
		nxt_low_cnt = sample_b ? 8'h00 : (low_cnt_ff + 8'h01);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			low_cnt_ff <= 8'h00;
		end else begin
			low_cnt_ff <= nxt_low_cnt;
		end
	end

	sequence s_tied_fall;
		$fell(sample_b) ##0 $fell(read_b);
	endsequence

	sequence s_data_wait;
		!done_b [*4] ##1 $rose(irq_stat_ff[`MAHI_IRQ_DONE]);
	endsequence

	a_sample_width: assert property (@(posedge clk) disable iff (!rst_b)
		($rose(sample_b) && !tied_ff) |-> (low_cnt_ff >= 8'h0F))
		else $error("sample strobe low too short");

	a_cs_with_strobe: assert property (@(posedge clk) disable iff (!rst_b)
		(!sample_b || !read_b) |-> !cs_b)
		else $error("strobe low without chip select");

	a_tied_together: assert property (@(posedge clk) disable iff (!rst_b)
		($fell(sample_b) && tied_ff) |-> s_tied_fall)
		else $error("tied strobes did not fall together");

	a_read_after_done: assert property (@(posedge clk) disable iff (!rst_b)
		($fell(read_b) && !tied_ff) |-> !$past(done_b))
		else $error("read strobe before done flag");

	a_pick_stable: assert property (@(posedge clk) disable iff (!rst_b)
		(!cs_b && !$fell(cs_b)) |-> $stable({channel_pick_hi, channel_pick_lo}))
		else $error("channel picks moved while selected");

	a_pick_two_in: assert property (@(posedge clk) disable iff (!rst_b)
		(!four_ff && !cs_b) |-> !channel_pick_hi && (channel_pick_lo == chan_ff[0]))
		else $error("two-input pick wrong");

	a_pick_four_in: assert property (@(posedge clk) disable iff (!rst_b)
		($fell(cs_b) && four_ff) |-> ({channel_pick_hi, channel_pick_lo} == chan_ff))
		else $error("four-input pick wrong");

	a_tied_data_wait: assert property (@(posedge clk) disable iff (!rst_b)
		($fell(done_b) && tied_ff) |-> s_data_wait ##0 (result_ff == $past(conv_data)))
		else $error("tied result taken too early");

	a_done_release: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(cs_b) |-> cs_b [*5])
		else $error("new conversion before recovery gap");

endmodule

`default_nettype wire

// ### verif/mahi_adc_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Converter model
// ----
module mahi_adc_model
	import mahi_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        cs_b,
	input  wire logic        sample_b,
	input  wire logic        read_b,
	input  wire logic        channel_pick_hi,
	input  wire logic        channel_pick_lo,
	input  wire logic        four,
	input  wire logic        mute,
	input  wire logic [4:0]  slow,
	input  wire logic [39:0] vin,
	output logic             done_b,
	output logic      [9:0]  conv_data
);
	logic       s_on, r_on, s_q, r_q, tmode, run;
	logic [9:0] sel, res, last;
	logic [5:0] coarse;
	int         cnt, rcnt, dcnt;

	assign s_on = !cs_b && !sample_b;
	assign r_on = !cs_b && !read_b;
	// Bus floats when not valid, so show a pattern that keeps changing
	assign conv_data = (r_on && (tmode ? (done_b || dcnt >= 2) : rcnt >= 3)) ? res : ~last;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{s_q, r_q, tmode, run, sel, res, last, coarse} <= '0;
			done_b <= 1'b1;
			cnt <= 0;
			rcnt <= 0;
			dcnt <= 0;
		end else begin
			s_q <= s_on;
			r_q <= r_on;
			last <= conv_data;
			cnt <= cnt + 1;
			rcnt <= r_on ? rcnt + 1 : 0;
			dcnt <= done_b ? 0 : dcnt + 1;
			if (s_on && !s_q) begin
				sel <= four ? vin[{channel_pick_hi, channel_pick_lo} * 10 +: 10]
					: vin[channel_pick_lo * 10 +: 10];
				tmode <= r_on;
				run <= 1'b1;
				cnt <= 0;
			end
			if (!s_on && s_q && !tmode) begin
				coarse <= sel[9:4];
				cnt <= 0;
			end
			if (run && (tmode || !s_on) && cnt == (tmode ? 47 : 36) + slow) begin
				res <= tmode ? sel : {coarse, sel[3:0]};
				done_b <= 1'b0;
				run <= 1'b0;
			end
			// A muted device never finishes
			if (mute)
				run <= 1'b0;
			if (!r_on && r_q)
				done_b <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Bench
// ----
module tb_top
	import mahi_pkg::*;
;
	logic        clk, rst_b, wr, rd, four, tied, mute, p_s, p_r;
	logic [4:0]  addr;
	logic [4:0]  slow;
	logic [31:0] wdata, rdata, d, r_exp;
	logic        irq, cs_b, sample_b, read_b, channel_pick_hi, channel_pick_lo, done_b;
	logic [9:0]  conv_data;
	logic [39:0] vin;
	logic [1:0]  exp_ch, msk;
	int          mismatches, num_checks, seed, lowc, exp_q[$];

	mahi_ctrl #(.TW(8)) uut (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .irq, .cs_b,
		.sample_b, .read_b, .channel_pick_hi, .channel_pick_lo, .done_b, .conv_data);
	mahi_adc_model dev (.clk, .rst_b, .cs_b, .sample_b, .read_b, .channel_pick_hi,
		.channel_pick_lo, .four, .mute, .slow, .vin, .done_b, .conv_data);

	always #5 clk = ~clk;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_reg(input logic [4:0] a, output logic [31:0] q);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 q = rdata;
		@(posedge clk);
	endtask

	task automatic final_report;
		if (mismatches == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One whole conversion, with a start request that must be dropped
	task automatic convert(input logic [1:0] ch, input logic t, input logic f);
		int          n;
		logic [31:0] e;
		four <= f;
		tied <= t;
		vin <= 40'({$random(seed), $random(seed)});
		slow <= 5'($random(seed));
		exp_ch <= f ? ch : {1'b0, ch[0]};
		msk = 2'($random(seed));
		wr_reg(5'h10, {30'h0, msk});
		e = f ? vin[ch * 10 +: 10] : vin[ch[0] * 10 +: 10];
		if (!mute)
			exp_q.push_back(int'(e));
		wr_reg(5'h00, {26'h0, ch, 1'b0, f, t, 1'b1});
		wr_reg(5'h00, {26'h0, ~ch, 1'b0, ~f, ~t, 1'b1});
		n = 0;
		do begin
			rd_reg(5'h04, d);
			n++;
		end while (d[0] !== 1'b0 && n < 150);
		chk("status", 32'h2, d);
		rd_reg(5'h08, d);
		if (!mute)
			r_exp = exp_q.pop_front();
		chk("result", r_exp, {22'h0, d[9:0]});
		if (f && !mute)
			chk("res_chan", {30'h0, ch}, {30'h0, d[13:12]});
		rd_reg(5'h0C, d);
		chk("irq_stat", mute ? 32'h2 : 32'h1, d);
		chk("irq_pin", {31'h0, |(d[1:0] & msk)}, {31'h0, irq});
		wr_reg(5'h0C, 32'h3);
		rd_reg(5'h0C, d);
		chk("irq_clr", 32'h0, d | {31'h0, irq});
	endtask

	// Pin monitor: strobe order and widths as the host produces them
	always @(posedge clk) begin
		p_s <= sample_b;
		p_r <= read_b;
		lowc <= sample_b ? 0 : lowc + 1;
		if (!sample_b || !read_b)
			chk("cs_low", 32'h0, {31'h0, cs_b});
		if (!cs_b && !sample_b && p_s)
			chk("pick", {30'h0, exp_ch}, {30'h0, channel_pick_hi, channel_pick_lo});
		if (!cs_b && sample_b && !p_s && !tied)
			chk("sample_low", 32'h1, {31'h0, lowc >= 15});
		if (!cs_b && !read_b && p_r)
			chk("read_fall", 32'h0, {31'h0, tied ? sample_b : done_b});
	end

	initial begin
		#200000;
		mismatches++;
		final_report;
	end

	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		{wr, rd, four, tied, mute, addr, wdata, slow, vin, exp_ch, r_exp} = '0;
		seed = 16;
		repeat (12) @(posedge clk);
		chk("reset_pins", 32'h1C, {27'h0, cs_b, sample_b, read_b, channel_pick_hi,
			channel_pick_lo});
		rst_b <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			rd_reg(5'(i * 4), d);
			chk("reset_val", (i == 1) ? 32'h2 : 32'h0, d);
		end
		for (int m = 0; m < 4; m++) begin
			for (int c = 0; c < 4; c++) begin
				convert(2'(c), m[1], m[0]);
			end
		end
		// The device stays silent: timeout, old result kept
		mute <= 1'b1;
		convert(2'h2, 1'b0, 1'b1);
		convert(2'h3, 1'b1, 1'b1);
		mute <= 1'b0;
		convert(2'h1, 1'b1, 1'b1);
		final_report;
	end
endmodule
`default_nettype wire
